// *** src/bttd_top.sv ***
// Bus trace trigger debugger: comparators, trace FIFO, breakpoints, Avalon slave
// Contract
// - Two 16-bit comparators, each optional read/write qualify.
// - Opcode qualify triggers only on actual execution.
// - Magnitude compares give inside and outside ranges.
// - Background controller accesses never produce matches.
// - A compares address; B address or data.
// - Full modes use write data when A expects write.
// - Match breaks, stores data, starts or stops tracing.
// - Eight-deep FIFO with valid word count status.
// - High then low read; low read advances.
// - Event modes store bytes; low read alone advances.
// - Begin trigger and next two bus cycles' flows not stored.
// - End trace stores a flowing trigger last.
// - Unarmed low read pushes last fetched opcode address.
// - Taken conditional branch stores source; ALWAYS_BRANCH_OP-type nothing.
// - Indirect jumps, calls, vectors, returns store destination.
// - Force request acts after current instruction completes.
// - Tag request marks opcode; executes as background entry.
// - Independent opcode tracker for each comparator.
// - Arm starts run, clears hit flags and count.
// - Begin ends full, end on trigger, disarm stops.
// - Begin bit selects start-at-trigger or circular storing.
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module bttd_top #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_bus_valid,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rw,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] cpu_wdata,
  input wire logic bdc_access,
  input wire logic opcode_fetch,
  input wire logic exec_valid,
  input wire logic [15:0] exec_addr,
  input wire logic queue_flush,
  input wire logic cof_valid,
  input wire logic [1:0] cof_kind,
  input wire logic [15:0] cof_src_addr,
  input wire logic [15:0] cof_dst_addr,
  input wire logic brk_ack,
  output logic brk_force_req,
  output logic brk_tag_req
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] CNT_FULL = FIFO_DEPTH[PW:0];

  function automatic logic rw_ok(input logic en, input logic exp, input logic rw);
    rw_ok = !en || (rw == exp);
  endfunction

  function automatic logic is_event(input logic [3:0] m);
    is_event = (m == bttd_pkg::TM_EVT_B) || (m == bttd_pkg::TM_A_THEN_EVT_B);
  endfunction

  function automatic logic is_full(input logic [3:0] m);
    is_full = (m == bttd_pkg::TM_A_AND_DATA) || (m == bttd_pkg::TM_A_AND_NOT_DATA);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d;
  logic [7:0] ctl_q, ctl_d, trg_q, trg_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  bttd_pkg::bttd_run_t run_q, run_d;
  logic run_end_q, run_end_d;
  logic af_q, af_d, bf_q, bf_d, a_seen_q, a_seen_d;
  logic [1:0] blank_q, blank_d;
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] count_q, count_d;
  logic [15:0] mem_q [FIFO_DEPTH];
  logic [15:0] last_fetch_q, last_fetch_d;
  logic force_q, force_d, tag_q, tag_d;

  logic acc, lo_rd, wr_ctl, wr_arm, wr_stop;
  logic bus_ok, raw_a, raw_b, dm, ha, hb, in_rng, trig, armed, tag_hit;
  logic push, pop, pop_eff;
  logic [15:0] push_data;
  logic [7:0] data_byte;
  logic [3:0] mode;
  wire [1:0] trk_fire;

  assign mode = trg_q[3:0];
  assign armed = (run_q != bttd_pkg::RS_IDLE);

  // ----------------------------------------------------------------
  // Opcode trackers, one per comparator
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : gen_trk
      logic pend_q, pend_d;
      logic [15:0] addr_q, addr_d;
      logic [15:0] cval;
      logic qual, feed;
      assign cval = (gi == 0) ? cmp_a_q : cmp_b_q;
      assign qual = (gi == 0) ?
        rw_ok(ctl_q[bttd_pkg::CTL_CMP_A_RW_QUALIFY_EN_BIT], ctl_q[bttd_pkg::CTL_RWA_BIT], cpu_rw) :
        rw_ok(ctl_q[bttd_pkg::CTL_RWBEN_BIT], ctl_q[bttd_pkg::CTL_RWB_BIT], cpu_rw);
      assign feed = bus_ok && opcode_fetch && (cpu_addr == cval) && qual;
      // Fires only when the tagged opcode leaves the queue executed
      assign trk_fire[gi] = pend_q && exec_valid && (exec_addr == addr_q);
      always_comb
      begin
        pend_d = pend_q;
        addr_d = addr_q;
        if (trk_fire[gi] || queue_flush)
          pend_d = 1'b0;
        if (feed)
        begin
          pend_d = 1'b1;
          addr_d = cpu_addr;
        end
      end
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          pend_q <= 1'b0;
          addr_q <= 16'h0000;
        end
        else if (ce)
        begin
          pend_q <= pend_d;
          addr_q <= addr_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Comparators and trigger
  // ----------------------------------------------------------------
  always_comb
  begin
    bus_ok = cpu_bus_valid && !bdc_access;
    data_byte = (ctl_q[bttd_pkg::CTL_CMP_A_RW_QUALIFY_EN_BIT] && !ctl_q[bttd_pkg::CTL_RWA_BIT]) ?
      cpu_wdata : cpu_rdata;
    raw_a = bus_ok && (cpu_addr == cmp_a_q) &&
      rw_ok(ctl_q[bttd_pkg::CTL_CMP_A_RW_QUALIFY_EN_BIT], ctl_q[bttd_pkg::CTL_RWA_BIT], cpu_rw);
    raw_b = bus_ok && (cpu_addr == cmp_b_q) &&
      rw_ok(ctl_q[bttd_pkg::CTL_RWBEN_BIT], ctl_q[bttd_pkg::CTL_RWB_BIT], cpu_rw);
    dm = (data_byte == cmp_b_q[7:0]);
    ha = trg_q[bttd_pkg::TRG_SEL_BIT] ? trk_fire[0] : raw_a;
    hb = trg_q[bttd_pkg::TRG_SEL_BIT] ? trk_fire[1] : raw_b;
    in_rng = (cpu_addr >= cmp_a_q) && (cpu_addr <= cmp_b_q);
    case (mode)
      bttd_pkg::TM_A_ONLY: trig = ha;
      bttd_pkg::TM_A_OR_B: trig = ha || hb;
      bttd_pkg::TM_A_THEN_B: trig = a_seen_q && hb;
      bttd_pkg::TM_EVT_B: trig = hb;
      bttd_pkg::TM_A_THEN_EVT_B: trig = a_seen_q && hb;
      bttd_pkg::TM_A_AND_DATA: trig = ha && dm;
      bttd_pkg::TM_A_AND_NOT_DATA: trig = ha && !dm;
      bttd_pkg::TM_INSIDE: trig = bus_ok && in_rng &&
        rw_ok(ctl_q[bttd_pkg::CTL_CMP_A_RW_QUALIFY_EN_BIT], ctl_q[bttd_pkg::CTL_RWA_BIT], cpu_rw);
      bttd_pkg::TM_OUTSIDE: trig = bus_ok && !in_rng &&
        rw_ok(ctl_q[bttd_pkg::CTL_CMP_A_RW_QUALIFY_EN_BIT], ctl_q[bttd_pkg::CTL_RWA_BIT], cpu_rw);
      default: trig = 1'b0;
    endcase
    // Full modes tag on the address match alone
    tag_hit = is_full(mode) ? raw_a : trig;
  end

  // ----------------------------------------------------------------
  // Bus slave, run control and FIFO
  // ----------------------------------------------------------------
  always_comb
  begin
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    ctl_d = ctl_q;
    trg_d = trg_q;
    run_d = run_q;
    run_end_d = run_end_q;
    a_seen_d = a_seen_q;
    blank_d = blank_q;
    last_fetch_d = last_fetch_q;
    rdata_d = rdata_q;
    push = 1'b0;
    pop = 1'b0;
    push_data = 16'h0000;
    // Request answered one cycle after it appears, then taken
    acc = (avs_read || avs_write) && !wait_q;
    wait_d = !((avs_read || avs_write) && wait_q);
    lo_rd = acc && avs_read && (avs_address == bttd_pkg::REG_FIFO_LO);
    wr_ctl = acc && avs_write && (avs_address == bttd_pkg::REG_DEBUG_CTL) && avs_byteenable[0];
    wr_arm = wr_ctl && avs_writedata[bttd_pkg::CTL_ARM_BIT] &&
      avs_writedata[bttd_pkg::CTL_EN_BIT];
    wr_stop = wr_ctl && !wr_arm;
    if (avs_read && wait_q)
    begin
      rdata_d = 32'h0000_0000;
      if (avs_address == bttd_pkg::REG_CMP_A)
        rdata_d[15:0] = cmp_a_q;
      else if (avs_address == bttd_pkg::REG_CMP_B)
        rdata_d[15:0] = cmp_b_q;
      else if (avs_address == bttd_pkg::REG_FIFO_HI)
        rdata_d[7:0] = mem_q[rd_q][15:8];
      else if (avs_address == bttd_pkg::REG_FIFO_LO)
        rdata_d[7:0] = mem_q[rd_q][7:0];
      else if (avs_address == bttd_pkg::REG_DEBUG_CTL)
      begin
        rdata_d[7:0] = ctl_q;
        rdata_d[bttd_pkg::CTL_ARM_BIT] = armed;
      end
      else if (avs_address == bttd_pkg::REG_TRIG_CTL)
        rdata_d[7:0] = trg_q;
      else if (avs_address == bttd_pkg::REG_STATUS)
      begin
        rdata_d[bttd_pkg::STS_AF_BIT] = af_q;
        rdata_d[bttd_pkg::STS_BF_BIT] = bf_q;
        rdata_d[bttd_pkg::STS_RUN_ARMED_FLAG_BIT] = armed;
        rdata_d[PW:0] = count_q;
      end
    end
    if (acc && avs_write)
    begin
      if (avs_address == bttd_pkg::REG_CMP_A)
      begin
        if (avs_byteenable[0])
          cmp_a_d[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1])
          cmp_a_d[15:8] = avs_writedata[15:8];
      end
      else if (avs_address == bttd_pkg::REG_CMP_B)
      begin
        if (avs_byteenable[0])
          cmp_b_d[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1])
          cmp_b_d[15:8] = avs_writedata[15:8];
      end
      else if (avs_address == bttd_pkg::REG_TRIG_CTL && avs_byteenable[0])
        trg_d = avs_writedata[7:0];
      else if (wr_ctl)
        ctl_d = avs_writedata[7:0] & ~(8'h01 << bttd_pkg::CTL_ARM_BIT);
    end
    if (bus_ok && opcode_fetch)
      last_fetch_d = cpu_addr;
    if (cpu_bus_valid && blank_q != 2'h0)
      blank_d = blank_q - 2'h1;
    if (armed && ha)
      a_seen_d = 1'b1;
    // Low port read: armed pops, unarmed profiles
    if (lo_rd)
      pop = armed ? (count_q != '0) : (count_q == CNT_FULL);
    case (run_q)
      bttd_pkg::RS_IDLE:
      begin
        if (lo_rd)
        begin
          push = 1'b1;
          push_data = last_fetch_q;
        end
      end
      bttd_pkg::RS_WAIT:
      begin
        if (trig && is_event(mode))
        begin
          push = 1'b1;
          push_data = {8'h00, cpu_rw ? cpu_rdata : cpu_wdata};
        end
        else if (trig)
        begin
          run_d = bttd_pkg::RS_STORE;
          blank_d = bttd_pkg::BLANK_BUS_CYCLES;
        end
      end
      bttd_pkg::RS_STORE:
      begin
        if (cof_valid && blank_q == 2'h0 && cof_kind != bttd_pkg::COF_UNCOND)
        begin
          push = 1'b1;
          push_data = (cof_kind == bttd_pkg::COF_COND_TAKEN) ?
            cof_src_addr : cof_dst_addr;
        end
        if (run_end_q && trig)
          run_d = bttd_pkg::RS_IDLE;
      end
      default: run_d = bttd_pkg::RS_IDLE;
    endcase
    // A full circular FIFO drops its oldest entry
    pop_eff = pop || (push && count_q == CNT_FULL && !pop);
    count_d = count_q + (PW + 1)'(push) - (PW + 1)'(pop_eff);
    if (armed && !run_end_q && count_d == CNT_FULL)
      run_d = bttd_pkg::RS_IDLE;
    if (wr_stop)
      run_d = bttd_pkg::RS_IDLE;
    if (wr_arm)
    begin
      run_end_d = !trg_q[bttd_pkg::TRG_BEGIN_BIT] && !is_event(mode);
      run_d = run_end_d ? bttd_pkg::RS_STORE : bttd_pkg::RS_WAIT;
      a_seen_d = 1'b0;
      blank_d = 2'h0;
      push = 1'b0;
      pop_eff = 1'b0;
      count_d = '0;
    end
    wr_d = wr_arm ? '0 : wr_q + PW'(push);
    rd_d = wr_arm ? '0 : rd_q + PW'(pop_eff);
    // Hit flags: a new hit during a run wins over the arm clear
    af_d = (wr_arm ? 1'b0 : af_q) || (armed && ha);
    bf_d = (wr_arm ? 1'b0 : bf_q) || (armed && hb);
    // Force request held until the CPU takes it at an instruction boundary
    force_d = (force_q && !brk_ack) || (armed && trig && ctl_q[bttd_pkg::CTL_BRKEN_BIT] &&
      !ctl_q[bttd_pkg::CTL_TAG_BIT]);
    tag_d = armed && tag_hit && opcode_fetch && ctl_q[bttd_pkg::CTL_BRKEN_BIT] &&
      ctl_q[bttd_pkg::CTL_TAG_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cmp_a_q <= bttd_pkg::CMP_RST;
      cmp_b_q <= bttd_pkg::CMP_RST;
      ctl_q <= bttd_pkg::CTL_RST;
      trg_q <= bttd_pkg::TRG_RST;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      run_q <= bttd_pkg::RS_IDLE;
      run_end_q <= 1'b0;
      af_q <= 1'b0;
      bf_q <= 1'b0;
      a_seen_q <= 1'b0;
      blank_q <= 2'h0;
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      last_fetch_q <= 16'h0000;
      force_q <= 1'b0;
      tag_q <= 1'b0;
    end
    else if (ce)
    begin
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      ctl_q <= ctl_d;
      trg_q <= trg_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      run_q <= run_d;
      run_end_q <= run_end_d;
      af_q <= af_d;
      bf_q <= bf_d;
      a_seen_q <= a_seen_d;
      blank_q <= blank_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
      last_fetch_q <= last_fetch_d;
      force_q <= force_d;
      tag_q <= tag_d;
      if (push)
        mem_q[wr_q] <= push_data;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign brk_force_req = force_q;
  assign brk_tag_req = tag_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_BDC_SUPPRESS: assert property (
    @(posedge ref_clk) disable iff (srst) bdc_access |-> !raw_a && !raw_b && !trig)
    else $error("match during background access");
  AST_WDATA_SEL: assert property (
    @(posedge ref_clk) disable iff (srst)
    ctl_q[bttd_pkg::CTL_CMP_A_RW_QUALIFY_EN_BIT] && !ctl_q[bttd_pkg::CTL_RWA_BIT] |-> data_byte == cpu_wdata)
    else $error("wrong data bus for comparator B");
  AST_ARM_CLEARS: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && wr_arm && !ha && !hb |=> count_q == '0 && armed && !af_q && !bf_q)
    else $error("arm did not start a clean run");
  AST_BEGIN_FULL: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && armed && !run_end_q && !wr_arm && count_d == CNT_FULL |=> run_q == bttd_pkg::RS_IDLE)
    else $error("begin run did not end at full");
  AST_PROFILE: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && lo_rd && !armed && !wr_arm && count_q != CNT_FULL |=>
    count_q == $past(count_q) + 1'b1 && mem_q[$past(wr_q)] == $past(last_fetch_q))
    else $error("profiling read did not push last fetch");
  AST_BLANK: assert property (
    @(posedge ref_clk) disable iff (srst)
    run_q == bttd_pkg::RS_WAIT && trig && !is_event(mode) && ce && !wr_arm && !wr_stop
    |=> blank_q == 2'h2 && !push)
    else $error("flow stored inside blanking window");
  AST_FORCE_HOLD: assert property (
    @(posedge ref_clk) disable iff (srst) force_q && !brk_ack |=> force_q)
    else $error("force request dropped before acknowledge");
  AST_EVENT_BYTE: assert property (
    @(posedge ref_clk) disable iff (srst)
    push && run_q == bttd_pkg::RS_WAIT |-> push_data[15:8] == 8'h00)
    else $error("event store wider than a byte");
  AST_BUS_ANSWER: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q || !ce)
    else $error("slave answer not one cycle");
  AST_UNCOND_NONE: assert property (
    @(posedge ref_clk) disable iff (srst)
    run_q == bttd_pkg::RS_STORE && cof_kind == bttd_pkg::COF_UNCOND |-> !push)
    else $error("unconditional branch stored");

  CVR_BEGIN_FILL: cover property (
    @(posedge ref_clk) disable iff (srst) armed && !run_end_q ##1 !armed && count_q == CNT_FULL);
  CVR_END_TRIG: cover property (
    @(posedge ref_clk) disable iff (srst) run_q == bttd_pkg::RS_STORE && run_end_q && trig);
  CVR_FORCE: cover property (
    @(posedge ref_clk) disable iff (srst) force_q ##1 brk_ack);
  CVR_PROFILE: cover property (
    @(posedge ref_clk) disable iff (srst) lo_rd && !armed && count_q == CNT_FULL);

endmodule

// *** inc/bttd_pkg.sv ***
// Constants and types shared by the bus trace trigger debugger
package bttd_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CMP_A = 5'h00;
  localparam logic [4:0] REG_CMP_B = 5'h04;
  localparam logic [4:0] REG_FIFO_HI = 5'h08;
  localparam logic [4:0] REG_FIFO_LO = 5'h0C;
  localparam logic [4:0] REG_DEBUG_CTL = 5'h10;
  localparam logic [4:0] REG_TRIG_CTL = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_ARM_BIT = 6;
  localparam int CTL_TAG_BIT = 5;
  localparam int CTL_BRKEN_BIT = 4;
  localparam int CTL_RWA_BIT = 3;
  localparam int CTL_CMP_A_RW_QUALIFY_EN_BIT = 2;
  localparam int CTL_RWB_BIT = 1;
  localparam int CTL_RWBEN_BIT = 0;
  localparam int TRG_SEL_BIT = 7;
  localparam int TRG_BEGIN_BIT = 6;
  localparam int STS_AF_BIT = 7;
  localparam int STS_BF_BIT = 6;
  localparam int STS_RUN_ARMED_FLAG_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] TRG_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [1:0] BLANK_BUS_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TM_A_ONLY = 4'h0,
    TM_A_OR_B = 4'h1,
    TM_A_THEN_B = 4'h2,
    TM_EVT_B = 4'h3,
    TM_A_THEN_EVT_B = 4'h4,
    TM_A_AND_DATA = 4'h5,
    TM_A_AND_NOT_DATA = 4'h6,
    TM_INSIDE = 4'h7,
    TM_OUTSIDE = 4'h8
  } bttd_mode_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'h0,
    RS_WAIT = 2'h1,
    RS_STORE = 2'h2
  } bttd_run_t;

  typedef enum logic [1:0] {
    COF_COND_TAKEN = 2'h0,
    COF_UNCOND = 2'h1,
    COF_INDIRECT = 2'h2,
    COF_VECTOR = 2'h3
  } bttd_cof_t;

endpackage

// *** verification/bttd_cpu_model.sv ***
// CPU-side partner model: bus cycles, execution reports, break acknowledge
`timescale 1ns/10ps
module bttd_cpu_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [2:0] ack_dly,
  input wire logic brk_force_req,
  output logic cpu_bus_valid,
  output logic [15:0] cpu_addr,
  output logic cpu_rw,
  output logic [7:0] cpu_rdata,
  output logic [7:0] cpu_wdata,
  output logic bdc_access,
  output logic opcode_fetch,
  output logic exec_valid,
  output logic [15:0] exec_addr,
  output logic queue_flush,
  output logic cof_valid,
  output logic [1:0] cof_kind,
  output logic [15:0] cof_src_addr,
  output logic [15:0] cof_dst_addr,
  output logic brk_ack
);
  logic [2:0] wait_q;

  initial
  begin
    {cpu_addr, cpu_rw, cpu_rdata, cpu_wdata, exec_addr, cof_src_addr, cof_dst_addr} = '0;
    {cpu_bus_valid, bdc_access, opcode_fetch, exec_valid, cof_valid, cof_kind, queue_flush} = '0;
  end

  // Idle bus: no strobes, lines keep changing
  task automatic idle();
    {cpu_bus_valid, bdc_access, opcode_fetch, cof_valid} <= 4'h0;
    {cpu_addr, cpu_rdata, cpu_wdata} <= ~{cpu_addr, cpu_rdata, cpu_wdata};
    {cof_src_addr, cof_dst_addr} <= ~{cof_src_addr, cof_dst_addr};
  endtask

  task automatic cyc(input logic [15:0] a, input logic rw, input logic [7:0] d,
    input logic bdc, input logic [2:0] cf);
    @(posedge ref_clk);
    cpu_bus_valid <= 1'b1;
    cpu_addr <= a;
    cpu_rw <= rw;
    cpu_rdata <= rw ? d : ~d;
    cpu_wdata <= rw ? ~d : d;
    bdc_access <= bdc;
    opcode_fetch <= rw & ~bdc;
    cof_valid <= cf[2];
    cof_kind <= cf[1:0];
    cof_src_addr <= a;
    cof_dst_addr <= ~a;
    @(posedge ref_clk);
    idle();
  endtask

  task automatic exec(input logic [15:0] a);
    @(posedge ref_clk);
    exec_valid <= 1'b1;
    exec_addr <= a;
    @(posedge ref_clk);
    exec_valid <= 1'b0;
    exec_addr <= ~a;
  endtask

  // Instruction queue thrown away for one cycle
  task automatic flush();
    @(posedge ref_clk);
    queue_flush <= 1'b1;
    @(posedge ref_clk);
    queue_flush <= 1'b0;
  endtask

  // Break taken at an instruction boundary after a variable delay
  always @(posedge ref_clk)
  begin
    brk_ack <= 1'b0;
    if (srst)
      wait_q <= 3'h0;
    else if (brk_force_req && !brk_ack)
    begin
      wait_q <= wait_q + 3'h1;
      if (wait_q >= ack_dly)
      begin
        brk_ack <= 1'b1;
        wait_q <= 3'h0;
      end
    end
  end
endmodule

// *** verification/bttd_top_tb_top.sv ***
// Self-checking testbench for the bus trace trigger debugger
`timescale 1ns/10ps
module bttd_top_tb_top;
  logic ref_clk, srst, avs_read, avs_write, avs_waitrequest, brk_force_req, brk_tag_req;
  logic cpu_bus_valid, cpu_rw, bdc_access, opcode_fetch, exec_valid, queue_flush, cof_valid;
  logic brk_ack;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [15:0] cpu_addr, exec_addr, cof_src_addr, cof_dst_addr, a;
  logic [7:0] cpu_rdata, cpu_wdata, d;
  logic [1:0] cof_kind, k;
  logic [2:0] ack_dly;
  logic [15:0] q[$];
  int errors, tests_run, i;

  bttd_top u_dut (.ref_clk, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .cpu_bus_valid,
    .cpu_addr, .cpu_rw, .cpu_rdata, .cpu_wdata, .bdc_access, .opcode_fetch, .exec_valid,
    .exec_addr, .queue_flush, .cof_valid, .cof_kind, .cof_src_addr, .cof_dst_addr,
    .brk_ack, .brk_force_req, .brk_tag_req);

  bttd_cpu_model u_cpu (.ref_clk, .srst, .ack_dly, .brk_force_req, .cpu_bus_valid, .cpu_addr,
    .cpu_rw, .cpu_rdata, .cpu_wdata, .bdc_access, .opcode_fetch, .exec_valid, .exec_addr,
    .queue_flush, .cof_valid, .cof_kind, .cof_src_addr, .cof_dst_addr, .brk_ack);

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic [4:0] ad, input logic w, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= wd;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    chk({31'h0, avs_waitrequest}, 32'h0, "avs_waitrequest");
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic sts(input logic [31:0] m, input logic [31:0] e);
    xfer(bttd_pkg::REG_STATUS, 1'b0, 32'h0);
    chk(rv & m, e, "status");
  endtask

  task automatic arm(input logic [7:0] c, input logic [7:0] t, input logic [31:0] ab);
    ack_dly <= 3'($urandom_range(4, 0));
    xfer(bttd_pkg::REG_CMP_A, 1'b1, {16'h0, ab[31:16]});
    xfer(bttd_pkg::REG_CMP_B, 1'b1, {16'h0, ab[15:0]});
    xfer(bttd_pkg::REG_TRIG_CTL, 1'b1, {24'h0, t});
    xfer(bttd_pkg::REG_DEBUG_CTL, 1'b1, {24'h0, c});
    q.delete();
    sts(32'hEF, 32'h20);
  endtask

  task automatic expect_brk(input logic e);
    logic seen;
    int n;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      if (brk_force_req === 1'b1)
        seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, e}, "brk_force_req");
    n = 0;
    while (brk_force_req !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic rdfifo(input logic ev);
    logic [7:0] hi;
    hi = 8'h00;
    while (q.size() > 0)
    begin
      if (!ev)
      begin
        xfer(bttd_pkg::REG_FIFO_HI, 1'b0, 32'h0);
        hi = rv[7:0];
      end
      xfer(bttd_pkg::REG_FIFO_LO, 1'b0, 32'h0);
      chk({16'h0, hi, rv[7:0]}, {16'h0, q.pop_front()}, "fifo");
    end
  endtask

  task automatic tcase(input logic [7:0] c, input logic [7:0] t, input logic [31:0] ab,
    input logic [24:0] n, input logic [24:0] y);
    arm(c, t, ab);
    u_cpu.cyc(y[24:9], y[8], y[7:0], 1'b1, 3'h0);
    expect_brk(1'b0);
    u_cpu.cyc(n[24:9], n[8], n[7:0], 1'b0, 3'h0);
    expect_brk(1'b0);
    u_cpu.cyc(y[24:9], y[8], y[7:0], 1'b0, 3'h0);
    expect_brk(1'b1);
    sts(32'h20, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {avs_read, avs_write, avs_address, avs_writedata, ack_dly} = '0;
    srst = 1'b1;
    void'($urandom(32'h83f21bd5));
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    sts(32'hFF, 32'h0);
    chk({30'h0, brk_force_req, brk_tag_req}, 32'h0, "break outputs");
    xfer(5'h1C, 1'b1, 32'hFF);
    xfer(5'h1C, 1'b0, 32'h0);
    chk(rv, 32'h0, "unmapped");
    u_cpu.cyc(16'h7A5C, 1'b1, 8'h00, 1'b0, 3'h0);
    xfer(bttd_pkg::REG_FIFO_LO, 1'b0, 32'h0);
    sts(32'h2F, 32'h01);
    xfer(bttd_pkg::REG_CMP_A, 1'b1, 32'hBEEF);
    xfer(bttd_pkg::REG_CMP_A, 1'b0, 32'h0);
    chk(rv, 32'hBEEF, "cmp_a");
    $display("test reset done");
    tcase(8'hDC, 8'h00, 32'h12340000, {16'h1234, 9'h000}, {16'h1234, 9'h100});
    tcase(8'hD0, 8'h07, 32'h20002FFF, {16'h1FFF, 9'h100}, {16'h2FFF, 9'h100});
    tcase(8'hD0, 8'h08, 32'h20002FFF, {16'h2800, 9'h100}, {16'h3000, 9'h100});
    tcase(8'hD4, 8'h05, 32'h600000AB, {16'h6000, 9'h0AC}, {16'h6000, 9'h0AB});
    tcase(8'hD0, 8'h01, 32'h11112222, {16'h3333, 9'h100}, {16'h2222, 9'h100});
    tcase(8'hD0, 8'h02, 32'h55556666, {16'h5555, 9'h100}, {16'h6666, 9'h100});
    $display("test triggers done");
    arm(8'hF0, 8'h00, 32'h44400000);
    u_cpu.cyc(16'h4440, 1'b1, 8'h00, 1'b0, 3'h0);
    @(posedge ref_clk);
    chk({31'h0, brk_tag_req}, 32'h1, "brk_tag_req");
    @(posedge ref_clk);
    chk({31'h0, brk_tag_req}, 32'h0, "brk_tag_req");
    arm(8'hD0, 8'h80, 32'h44400000);
    u_cpu.cyc(16'h4440, 1'b1, 8'h00, 1'b0, 3'h0);
    expect_brk(1'b0);
    u_cpu.flush();
    u_cpu.exec(16'h4440);
    expect_brk(1'b0);
    u_cpu.cyc(16'h4440, 1'b1, 8'h00, 1'b0, 3'h0);
    u_cpu.exec(16'h4440);
    expect_brk(1'b1);
    $display("test tag and opcode done");
    arm(8'hC0, 8'h03, 32'h00005000);
    for (i = 0; i < 9; i++)
    begin
      d = 8'($urandom());
      u_cpu.cyc(16'h5001, i[0], ~d, 1'b0, 3'h0);
      u_cpu.cyc(16'h5000, i[1], d, 1'b0, 3'h0);
      if (i < 8)
        q.push_back({8'h00, d});
      if (i == 3)
        sts(32'h2F, 32'h24);
    end
    sts(32'h2F, 32'h08);
    rdfifo(1'b1);
    $display("test event capture done");
    arm(8'hC0, 8'h40, 32'h12340000);
    u_cpu.cyc(16'h1234, 1'b1, 8'h00, 1'b0, 3'h4);
    for (i = 0; i < 14; i++)
    begin
      a = 16'h4100 + 16'(i);
      k = 2'(i);
      u_cpu.cyc(a, 1'b1, 8'h00, 1'b0, {1'b1, k});
      if (i >= 2 && q.size() < 8 && k != 2'h1)
        q.push_back(k == 2'h0 ? a : ~a);
    end
    sts(32'h2F, 32'h08);
    rdfifo(1'b0);
    $display("test begin trace done");
    arm(8'hC0, 8'h00, 32'h12340000);
    for (i = 0; i < 11; i++)
    begin
      a = (i == 9) ? 16'h1234 : 16'h4200 + 16'(i);
      u_cpu.cyc(a, 1'b1, 8'h00, 1'b0, (i == 9) ? 3'h6 : 3'h4);
      if (i < 10)
        q.push_back((i == 9) ? ~a : a);
    end
    while (q.size() > 8)
      void'(q.pop_front());
    sts(32'h2F, 32'h08);
    rdfifo(1'b0);
    $display("test end trace done");
    q.push_back(16'h420A);
    rdfifo(1'b0);
    arm(8'hC0, 8'h00, 32'h12340000);
    u_cpu.cyc(16'h4300, 1'b1, 8'h00, 1'b0, 3'h4);
    xfer(bttd_pkg::REG_DEBUG_CTL, 1'b1, 32'h80);
    u_cpu.cyc(16'h1234, 1'b1, 8'h00, 1'b0, 3'h4);
    sts(32'h2F, 32'h01);
    $display("test profile and stop done");
    final_report();
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule
